// >>> aic_cpu_model.sv
// CPU core acceptance model: answers take after dly cycles, raises its mask.
// Assumes the bench pulses ret as the handler's return.
`timescale 1ns/100ps
module aic_cpu_model (
  input wire        clk, rst, take, ret,
  input wire [1:0]  lvl, base,
  input wire [3:0]  dly,
  output wire       accept,
  output wire [1:0] mask
);
  logic [3:0] cnt_q;
  logic       busy_q;
  // Accept is seen by the slice in the same cycle as its take.
  assign accept = take && !busy_q && !ret && !rst && (cnt_q == dly);
  always @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
    end else if (ret) begin
      busy_q <= 1'b0;
    end else if (take && !busy_q) begin
      cnt_q <= cnt_q + 4'h1;
      if (accept) begin
        busy_q <= 1'b1;
        cnt_q  <= 4'h0;
      end
    end
  end
  // Inside a handler the mask follows the current level on lvl.
  assign mask = busy_q ? lvl : base;
endmodule // aic_cpu_model

// >>> aic_defines.vh
// Constants for the conversion-completion interrupt control slice.
// Assumes byte-wide registers at 16-bit addresses on a plain strobe port.
`ifndef AIC_DEFINES_VH
`define AIC_DEFINES_VH
`define AIC_ADDR_W        16
`define AIC_DATA_W        8
`define AIC_OFS_PRIO      16'hff28
`define AIC_OFS_ENABLE    16'hff2a
`define AIC_OFS_FLAG      16'hff2c
`define AIC_OFS_IRQ_STAT  16'hff2e
`define AIC_OFS_IRQ_MASK  16'hff2f
`define AIC_OFS_VEC       16'hff30
`define AIC_BIT_LVL_HI    7
`define AIC_BIT_LVL_LO    6
`define AIC_BIT_ENABLE    7
`define AIC_BIT_PENDING   7
`define AIC_RST_BYTE      8'h00
`define AIC_RST_LVL       2'h0
`define AIC_VEC_W         16
`define AIC_VEC_DEFAULT   16'h0024
`define AIC_COMMON_TOP    16'h7fff
`define AIC_STAT_ACCEPT   0
`define AIC_STAT_RETRIG   1
`define AIC_STAT_NMI_HOLD 2
`define AIC_SLP_GUARD_NS  2000000
`define AIC_CLK_NS        25
`endif

// >>> aic_irq_ctrl.v
// Interrupt control slice for the conversion-completion source: priority field,
// enable bit, pending flag, CPU request with level, vector and sleep guard.
// Assumes a CPU core on the same clock and a converter event that may be asynchronous.
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "aic_defines.vh"
module aic_irq_ctrl #(
  parameter [`AIC_VEC_W-1:0] VECTOR      = `AIC_VEC_DEFAULT,
  parameter                  SLP_GUARD_CYC = `AIC_SLP_GUARD_NS / `AIC_CLK_NS
) (
  input  wire                   clk,
  input  wire                   rst,
  input  wire [`AIC_ADDR_W-1:0] reg_addr,
  input  wire [`AIC_DATA_W-1:0] reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [`AIC_DATA_W-1:0] reg_rdata,
  input  wire                   conv_done,
  input  wire                   cpu_mask_bit0,
  input  wire                   cpu_mask_bit1,
  input  wire                   cpu_accept,
  input  wire                   return_from_exception,
  input  wire                   nmi_event,
  output wire                   conv_irq_req,
  output wire [1:0]             conv_irq_level,
  output wire                   conv_irq_take,
  output reg  [`AIC_VEC_W-1:0]  conv_irq_vector,
  output wire                   sleep_blocked,
  output wire                   irq
);
  localparam integer GW = 32;

  // Returns the numeric level of a two-bit field, upper bit most significant.
  function [1:0] lvl_of;
    input hi;
    input lo;
    begin
      lvl_of = {hi, lo};
    end
  endfunction

  // True when the bus address selects the given register offset.
  function addr_is;
    input [`AIC_ADDR_W-1:0] addr;
    input [`AIC_ADDR_W-1:0] ofs;
    begin
      addr_is = (addr == ofs);
    end
  endfunction

  reg               conv_irq_level_hi_q;
  reg               conv_irq_level_lo_q;
  reg               conv_irq_enable_q;
  reg               conv_irq_pending_q;
  reg               in_service_q;
  reg  [2:0]        stat_q;
  reg  [2:0]        stat_d;
  reg  [2:0]        mask_q;
  reg  [GW-1:0]     guard_q;
  reg               done_prev_q;
  reg  [`AIC_DATA_W-1:0] rdata_d;
  wire              done_sync;
  wire              done_rise;
  wire              hit_prio;
  wire              hit_en;
  wire              hit_flag;
  wire              hit_stat;
  wire              hit_mask;
  wire              flag_clr;
  wire [1:0]        mask_lvl;
  wire              retrig;
  wire              wr_prio;
  wire              wr_en;
  wire              wr_stat;
  wire              wr_mask;
  wire              accepted;
  reg               conv_irq_level_hi_d;
  reg               conv_irq_level_lo_d;
  reg               conv_irq_enable_d;
  reg               conv_irq_pending_d;
  reg               in_service_d;
  reg  [2:0]        mask_d;
  reg  [GW-1:0]     guard_d;
  reg  [`AIC_VEC_W-1:0] vector_d;

  aic_sync3 u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (conv_done),
    .dout (done_sync)
  );

  assign done_rise = done_sync & ~done_prev_q;
  assign hit_prio  = addr_is(reg_addr, `AIC_OFS_PRIO);
  assign hit_en    = addr_is(reg_addr, `AIC_OFS_ENABLE);
  assign hit_flag  = addr_is(reg_addr, `AIC_OFS_FLAG);
  assign hit_stat  = addr_is(reg_addr, `AIC_OFS_IRQ_STAT);
  assign hit_mask  = addr_is(reg_addr, `AIC_OFS_IRQ_MASK);
  assign wr_prio   = reg_wr & hit_prio;
  assign wr_en     = reg_wr & hit_en;
  assign wr_stat   = reg_wr & hit_stat;
  assign wr_mask   = reg_wr & hit_mask;
  assign flag_clr  = reg_wr & hit_flag & reg_wdata[`AIC_BIT_PENDING];

  // The request stays up as long as the flag and the enable bit are set, so the CPU sees it again
  // after a return or a lowered mask without any extra event.
  assign conv_irq_req   = conv_irq_pending_q & conv_irq_enable_q;
  assign conv_irq_level = lvl_of(conv_irq_level_hi_q, conv_irq_level_lo_q);
  assign mask_lvl       = {cpu_mask_bit1, cpu_mask_bit0};
  // Level 0 can never exceed any mask setting, including 00.
  assign conv_irq_take  = conv_irq_req && (conv_irq_level > mask_lvl);
  assign accepted       = cpu_accept & conv_irq_take;
  assign retrig         = return_from_exception & in_service_q & conv_irq_pending_q;
  assign sleep_blocked  = guard_q != {GW{1'b0}};
  assign irq            = |(stat_q & mask_q);

  // The edge detector starts low, matching the synchroniser's reset level.
  always @(posedge clk) begin
    if (rst) begin
      done_prev_q <= 1'b0;
    end else begin
      done_prev_q <= done_sync;
    end
  end

  always @* begin
    conv_irq_level_hi_d = conv_irq_level_hi_q;
    conv_irq_level_lo_d = conv_irq_level_lo_q;
    if (wr_prio) begin
      conv_irq_level_hi_d = reg_wdata[`AIC_BIT_LVL_HI];
      conv_irq_level_lo_d = reg_wdata[`AIC_BIT_LVL_LO];
    end
  end

  always @* begin
    conv_irq_enable_d = conv_irq_enable_q;
    if (wr_en) begin
      conv_irq_enable_d = reg_wdata[`AIC_BIT_ENABLE];
    end
  end

  // A completion in the same cycle as a clear keeps the flag set.
  always @* begin
    conv_irq_pending_d = conv_irq_pending_q;
    if (done_rise) begin
      conv_irq_pending_d = 1'b1;
    end else if (flag_clr) begin
      conv_irq_pending_d = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      conv_irq_level_hi_q <= 1'b0;
      conv_irq_level_lo_q <= 1'b0;
      conv_irq_enable_q   <= 1'b0;
      conv_irq_pending_q  <= 1'b0;
    end else begin
      conv_irq_level_hi_q <= conv_irq_level_hi_d;
      conv_irq_level_lo_q <= conv_irq_level_lo_d;
      conv_irq_enable_q   <= conv_irq_enable_d;
      conv_irq_pending_q  <= conv_irq_pending_d;
    end
  end

  // Tracks whether the handler for this source is running, so that a return
  // with the flag still set can be told apart from an ordinary return.
  always @* begin
    in_service_d = in_service_q;
    if (accepted) begin
      in_service_d = 1'b1;
    end else if (return_from_exception) begin
      in_service_d = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      in_service_q <= 1'b0;
    end else begin
      in_service_q <= in_service_d;
    end
  end

  // A new non-maskable event restarts the whole guard span.
  always @* begin
    guard_d = guard_q;
    if (nmi_event) begin
      guard_d = SLP_GUARD_CYC;
    end else if (sleep_blocked) begin
      guard_d = guard_q - {{(GW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      guard_q <= {GW{1'b0}};
    end else begin
      guard_q <= guard_d;
    end
  end

  // Only the low fifteen bits of the vector are kept, so the entry is forced
  // into the common area that every bank can reach.
  always @* begin
    vector_d = VECTOR & `AIC_COMMON_TOP;
  end

  always @(posedge clk) begin
    if (rst) begin
      conv_irq_vector <= {`AIC_VEC_W{1'b0}};
    end else begin
      conv_irq_vector <= vector_d;
    end
  end

  always @* begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_d & ~reg_wdata[2:0];
    end
    if (accepted) begin
      stat_d[`AIC_STAT_ACCEPT] = 1'b1;
    end
    if (retrig) begin
      stat_d[`AIC_STAT_RETRIG] = 1'b1;
    end
    if (nmi_event) begin
      stat_d[`AIC_STAT_NMI_HOLD] = 1'b1;
    end
  end

  always @* begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = reg_wdata[2:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      mask_q <= 3'h0;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Unmapped addresses and reserved bits read as zero.
  always @* begin
    rdata_d = `AIC_RST_BYTE;
    case (reg_addr)
      `AIC_OFS_PRIO: begin
        rdata_d[`AIC_BIT_LVL_HI] = conv_irq_level_hi_q;
        rdata_d[`AIC_BIT_LVL_LO] = conv_irq_level_lo_q;
      end
      `AIC_OFS_ENABLE: begin
        rdata_d[`AIC_BIT_ENABLE] = conv_irq_enable_q;
      end
      `AIC_OFS_FLAG: begin
        rdata_d[`AIC_BIT_PENDING] = conv_irq_pending_q;
      end
      `AIC_OFS_IRQ_STAT: begin
        rdata_d[2:0] = stat_q;
      end
      `AIC_OFS_IRQ_MASK: begin
        rdata_d[2:0] = mask_q;
      end
      `AIC_OFS_VEC: begin
        rdata_d = conv_irq_vector[7:0];
      end
      default: begin
        rdata_d = `AIC_RST_BYTE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= `AIC_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= `AIC_RST_BYTE;
    end
  end
endmodule // aic_irq_ctrl

// >>> aic_irq_ctrl_chk.sv
// Port assertions for the conversion interrupt slice.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module aic_irq_ctrl_chk (
  input wire        clk, rst, reg_wr, reg_rd, cpu_mask_bit0, cpu_mask_bit1,
  input wire        conv_irq_req, conv_irq_take,
  input wire [15:0] reg_addr, conv_irq_vector,
  input wire [7:0]  reg_wdata, reg_rdata,
  input wire [1:0]  conv_irq_level
);
  wire [1:0] m = {cpu_mask_bit1, cpu_mask_bit0};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_take_above: assert property (conv_irq_take |-> conv_irq_level > m)
    else $error("take at or below mask");
  a_take_req: assert property (conv_irq_take |-> conv_irq_req)
    else $error("take without request");
  a_take_due: assert property (conv_irq_req && conv_irq_level > m |-> conv_irq_take)
    else $error("pending request not taken");
  a_clear_one: assert property (reg_wr && reg_addr == 16'hff2c && reg_wdata[7]
    |=> !conv_irq_req) else $error("request after clear");
  a_enable_off: assert property (reg_wr && reg_addr == 16'hff2a && !reg_wdata[7]
    |=> !conv_irq_req) else $error("request while disabled");
  a_level_wr: assert property (reg_wr && reg_addr == 16'hff28
    |=> conv_irq_level == $past(reg_wdata[7:6])) else $error("level not written");
  a_rst_level: assert property (disable iff (1'b0) rst |=> conv_irq_level == 2'h0)
    else $error("level not zero after reset");
  a_vec_common: assert property (!$past(rst) |-> conv_irq_vector <= 16'h7fff)
    else $error("vector outside common area");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside slot");
endmodule // aic_irq_ctrl_chk
bind aic_irq_ctrl aic_irq_ctrl_chk u_aic_irq_ctrl_chk (.*);

// >>> aic_irq_ctrl_test.sv
// Self-checking bench for the conversion interrupt slice.
// Assumes the CPU model and a 20-cycle sleep guard.
`timescale 1ns/100ps
module aic_irq_ctrl_test;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, conv_done = 0, ret = 0, nmi_event = 0, rd_d = 0;
  logic [15:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, q[$];
  logic [1:0]  base = 0;
  logic [3:0]  dly = 0;
  wire [7:0]   reg_rdata;
  wire [15:0]  conv_irq_vector;
  wire [1:0]   conv_irq_level, m;
  wire         conv_irq_req, conv_irq_take, cpu_accept, sleep_blocked, irq;
  int          err_count = 0, cmp_count = 0, i;
  always #12.5 clk = ~clk;
  aic_irq_ctrl #(.SLP_GUARD_CYC(20)) u_aic_irq_ctrl (.*, .cpu_mask_bit0(m[0]),
    .cpu_mask_bit1(m[1]), .return_from_exception(ret));
  aic_cpu_model u_aic_cpu_model (.clk(clk), .rst(rst), .take(conv_irq_take), .ret(ret),
    .lvl(conv_irq_level), .base(base), .dly(dly), .accept(cpu_accept), .mask(m));
  task chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (e !== g) begin
      err_count++;
      $display("ERROR %s expected %h got %h", n, e, g);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1; reg_addr <= a; q.push_back(e);
    @(posedge clk);
    reg_rd <= 0;
  endtask
  task pret;
    @(posedge clk) ret <= 1;
    @(posedge clk) ret <= 0;
  endtask
  task wreq;
    for (i = 0; i < 12 && conv_irq_req !== 1'b1; i++) @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (rd_d) chk("rdata", {8'h00, q.pop_front()}, {8'h00, reg_rdata});
    rd_d <= reg_rd;
  end
  task summarize;
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #75000 err_count++;
    summarize;
  end
  initial begin
    i = $urandom(35697);
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(16'hff28, 0); rd(16'hff2a, 0); rd(16'hff2c, 0); rd(16'hff40, 0);
    chk("vector", 16'h0024, conv_irq_vector);
    rd(16'hff30, 8'h24);
    for (int l = 0; l < 4; l++) begin
      wr(16'hff28, {2'(l), 6'h00});
      rd(16'hff28, {2'(l), 6'h00});
      @(negedge clk) chk("level", 16'(l), conv_irq_level);
    end
    dly <= 4'($urandom % 4);
    wr(16'hff2a, {1'b1, 7'($urandom)}); rd(16'hff2a, 8'h80);
    wr(16'hff28, 8'h80);
    conv_done <= 1;
    wreq; chk("req", 1, conv_irq_req);
    rd(16'hff2c, 8'h80); wr(16'hff2c, 8'h00); rd(16'hff2c, 8'h80);
    @(negedge clk) chk("take", 0, conv_irq_take);
    pret;
    @(negedge clk) chk("take", 1, conv_irq_take);
    wr(16'hff2c, 8'h80);
    @(negedge clk) chk("req", 0, conv_irq_req);
    pret;
    conv_done <= 0;
    repeat (6) @(posedge clk);
    wr(16'hff2a, 0);
    conv_done <= 1;
    wreq; chk("req", 0, conv_irq_req);
    wr(16'hff28, 0); wr(16'hff2a, 8'h80);
    @(negedge clk) chk("req", 1, conv_irq_req);
    chk("take", 0, conv_irq_take);
    wr(16'hff2c, 8'h80);
    wr(16'hff2f, 8'h01); @(negedge clk) chk("irq", 1, irq);
    wr(16'hff2f, 8'h00); @(negedge clk) chk("irq", 0, irq);
    wr(16'hff2f, 8'h07); wr(16'hff2e, 8'h07); rd(16'hff2e, 0);
    nmi_event <= 1;
    @(posedge clk) nmi_event <= 0;
    @(negedge clk) chk("sleep", 1, sleep_blocked);
    repeat (22) @(negedge clk);
    chk("sleep", 0, sleep_blocked);
    chk("irq", 1, irq);
    summarize;
  end
endmodule // aic_irq_ctrl_test

// >>> aic_sync3.v
// Three-stage synchroniser with a registered output flop, for a level that arrives from outside the clock domain.
// Assumes a single clock; the output changes only when the last two stages agree.
`timescale 1ns/100ps
module aic_sync3 (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // aic_sync3
